/* hdl/isa_dec_pkg.sv */
// Shared constants, types and helpers for the I/O decode and IRQ router.
// Behaviour
// RL1 - Compare address bits A9..A5 to five switches, switch one on A5.
// RL2 - Switch off expects a one on its bit, switch on expects zero.
// RL3 - Decode a 32 byte window; A4..A0 select the register.
// RL4 - Bases run 100 to 3E0 hex in 20 hex steps; below 100 excluded.
// RL5 - Out of reset the base is 340 hex, ports 340 to 35F.
// RL6 - Board interrupt reports status and errors on one selectable level.
// RL7 - Link interrupt follows the external request on its own level.
// RL8 - The link interrupt also raises the board interrupt.
// RL9 - Levels 3,4,5,6,7,9,10,11,12,14,15 or not used are selectable.
// RL10 - Default board level is 12, default link level is 10.
// RL11 - A request line stays undriven until software enables that level.
// RL12 - An enabled level in use is driven exclusively, never shared.
// RL13 - Host enables each chosen level and gives it to no other device.
// RL14 - I/O cycles with address enable high (DMA) are ignored.
package isa_dec_pkg;

  localparam int         ADDR_W          = 10;
  localparam int         SW_W            = 5;
  localparam int         OFS_W           = 5;
  localparam int         LVL_W           = 4;
  localparam int         IRQ_LINES       = 16;
  localparam int         WINDOW_BYTES    = 32;
  localparam logic [9:0] BASE_ADDR_MIN   = 10'h100;
  localparam logic [9:0] BASE_ADDR_MAX   = 10'h3e0;
  localparam logic [9:0] BASE_ADDR_STEP  = 10'h020;
  localparam logic [9:0] BASE_ADDR_RESET = 10'h340;
  localparam logic [4:0] SW_RESET        = BASE_ADDR_RESET[9:5];
  localparam logic [3:0] BOARD_LVL_RESET = 4'hc;
  localparam logic [3:0] LINK_LVL_RESET  = 4'ha;
  localparam logic [15:0] LEGAL_IRQ_MASK = 16'hdef8;
  localparam logic [15:0] IRQ_UNDRIVEN   = 16'hffff;

  // Capture the straps once, then run.
  typedef enum logic [1:0] {
    ST_CAPTURE = 2'b00,
    ST_RUN     = 2'b01
  } phase_t;

  // One host I/O cycle as seen on the bus pins.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              aen;
    logic              rd_n;
    logic              wr_n;
  } io_cycle_t;

  // One register access passed to the internal register set.
  typedef struct packed {
    logic             hit;
    logic             rd;
    logic             wr;
    logic [OFS_W-1:0] offset;
  } reg_access_t;

  // Whole state of the decode and routing block.
  typedef struct packed {
    phase_t           st;
    logic [SW_W-1:0]  base;
    logic [LVL_W-1:0] board_lvl;
    logic [LVL_W-1:0] link_lvl;
    reg_access_t      acc;
    logic [15:0]      irq;
    logic [15:0]      irq_oe_n;
  } dec_state_t;

  // True when a level number is one the board may drive.
  function automatic logic level_ok(input logic [LVL_W-1:0] lvl);
    level_ok = LEGAL_IRQ_MASK[lvl];
  endfunction

  // True when a switch setting gives a base at or above the minimum.
  function automatic logic base_ok(input logic [SW_W-1:0] sw);
    base_ok = ({sw, 5'h00} >= BASE_ADDR_MIN) &&
              ({sw, 5'h00} <= BASE_ADDR_MAX);
  endfunction

endpackage

/* hdl/irq_level_router.sv */
// Steers one interrupt source onto one selected request line.
`timescale 1ns/1ps
module irq_level_router #(
  parameter int LINES = 16
) (
  input  wire logic [isa_dec_pkg::LVL_W-1:0] level_i,  // Selected level.
  input  wire logic                          req_i,    // Source request.
  input  wire logic [LINES-1:0]              enable_i, // Software enables.
  output logic      [LINES-1:0]              drive_o,  // Line is driven.
  output logic      [LINES-1:0]              value_o   // Level on line.
);
  import isa_dec_pkg::*;

  // Each line is driven only when selected, legal and enabled.
  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_line
      assign drive_o[g] = (level_i == LVL_W'(g)) && LEGAL_IRQ_MASK[g] &&
                          enable_i[g]; // [RL9] [RL11]
      assign value_o[g] = drive_o[g] && req_i;
    end
  endgenerate

endmodule

/* hdl/isa_io_decode_irq_route.sv */
// I/O window decode and interrupt routing of the host bus interface.
`timescale 1ns/1ps
module isa_io_decode_irq_route (
  input  wire logic                         ref_clk_i,    // 25 MHz clock.
  input  wire logic                         rst_i,        // Async reset.
  input  wire isa_dec_pkg::io_cycle_t       io_i,         // Bus cycle pins.
  input  wire logic [isa_dec_pkg::SW_W-1:0] sw_off_i,     // Switch off = 1.
  input  wire logic [isa_dec_pkg::LVL_W-1:0] board_jmp_i, // Board level.
  input  wire logic [isa_dec_pkg::LVL_W-1:0] link_jmp_i,  // Link level.
  input  wire logic                         board_evt_i,  // Status/error.
  input  wire logic                         link_irq_i,   // Link request.
  input  wire logic [15:0]                  irq_en_i,     // Level enables.
  output isa_dec_pkg::reg_access_t          acc_o,        // Register access.
  output logic [isa_dec_pkg::SW_W-1:0]      base_o,       // Captured base.
  output logic                              base_ok_o,    // Base is legal.
  output logic [15:0]                       irq_o,        // Request levels.
  output logic [15:0]                       irq_oe_n_o    // Low = driven.
);
  import isa_dec_pkg::*;

  dec_state_t        cur_reg;
  dec_state_t        cur_next;
  logic [15:0]       board_drive;
  logic [15:0]       board_value;
  logic [15:0]       link_drive;
  logic [15:0]       link_value;
  logic              board_req;
  logic              io_req;
  logic              addr_match;

  // The link request is one of the board interrupt conditions.
  assign board_req = board_evt_i | link_irq_i; // [RL6] [RL8]

  // A processor cycle is a strobe with address enable low.
  assign io_req = (!io_i.rd_n || !io_i.wr_n) && !io_i.aen; // [RL14]

  // Upper address bits against the captured switch pattern.
  assign addr_match = (io_i.addr[9:5] == cur_reg.base) &&
                      base_ok(cur_reg.base); // [RL1] [RL4]

  // Board interrupt routing.
  irq_level_router #(
    .LINES (IRQ_LINES)
  ) u_board_route (
    .level_i  (cur_reg.board_lvl),
    .req_i    (board_req),
    .enable_i (irq_en_i),
    .drive_o  (board_drive),
    .value_o  (board_value)
  );

  // Link interrupt routing on its own level.
  irq_level_router #(
    .LINES (IRQ_LINES)
  ) u_link_route (
    .level_i  (cur_reg.link_lvl),
    .req_i    (link_irq_i),
    .enable_i (irq_en_i),
    .drive_o  (link_drive),
    .value_o  (link_value)
  );

  // Next state: strap capture, address decode and line drive.
  always_comb begin
    cur_next = cur_reg;
    cur_next.acc.hit    = 1'b0;
    cur_next.acc.rd     = 1'b0;
    cur_next.acc.wr     = 1'b0;
    cur_next.acc.offset = cur_reg.acc.offset;
    case (cur_reg.st)
      ST_CAPTURE: begin
        cur_next.base      = sw_off_i; // [RL2]
        cur_next.board_lvl = board_jmp_i;
        cur_next.link_lvl  = link_jmp_i;
        cur_next.st        = ST_RUN;
      end
      ST_RUN: begin
        if (io_req && addr_match) begin
          cur_next.acc.hit    = 1'b1; // [RL3]
          cur_next.acc.rd     = !io_i.rd_n;
          cur_next.acc.wr     = !io_i.wr_n;
          cur_next.acc.offset = io_i.addr[OFS_W-1:0]; // [RL3]
        end
      end
      default: begin
        cur_next.st = ST_CAPTURE;
      end
    endcase
    // Lines are driven push-pull only while enabled and selected.
    cur_next.irq      = board_value | link_value; // [RL7] [RL12]
    cur_next.irq_oe_n = ~(board_drive | link_drive); // [RL11]
  end

  // State register; the reset values are the factory settings.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_reg.st        <= ST_CAPTURE;
      cur_reg.base      <= SW_RESET; // [RL5]
      cur_reg.board_lvl <= BOARD_LVL_RESET; // [RL10]
      cur_reg.link_lvl  <= LINK_LVL_RESET; // [RL10]
      cur_reg.acc       <= '0;
      cur_reg.irq       <= '0;
      cur_reg.irq_oe_n  <= IRQ_UNDRIVEN;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // Outputs come from the state register; base_ok_o is decoded from the stored base.
  assign acc_o      = cur_reg.acc;
  assign base_o     = cur_reg.base;
  assign base_ok_o  = base_ok(cur_reg.base);
  assign irq_o      = cur_reg.irq;
  assign irq_oe_n_o = cur_reg.irq_oe_n;

  // Checks on decode and routing behaviour.
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  // A processor cycle inside the window.
  sequence s_window_cycle;
    io_req && addr_match && cur_reg.st == ST_RUN;
  endsequence

  // The register access that answers it one cycle later.
  sequence s_access_out;
    ##1 acc_o.hit && acc_o.offset == $past(io_i.addr[4:0]);
  endsequence

  // A request on the link with its level enabled.
  sequence s_link_enabled;
    link_irq_i && irq_en_i[cur_reg.link_lvl] &&
      level_ok(cur_reg.link_lvl);
  endsequence

  a_window_hit: assert property ( // [RL1] [RL3]
    s_window_cycle |-> s_access_out)
    else $error("Window cycle gave no register access.");

  a_dma_ignored: assert property ( // [RL14]
    io_i.aen |=> !acc_o.hit)
    else $error("Access decoded during a DMA cycle.");

  a_low_base_off: assert property ( // [RL4]
    (cur_reg.st == ST_RUN && cur_reg.base[4:3] == 2'b00) |=> !acc_o.hit)
    else $error("Base below 100 hex was decoded.");

  a_miss_quiet: assert property ( // [RL1]
    (io_i.addr[9:5] != cur_reg.base) |=> !acc_o.hit)
    else $error("Address outside the window was decoded.");

  a_switch_taken: assert property ( // [RL2]
    cur_reg.st == ST_CAPTURE |=> base_o == $past(sw_off_i))
    else $error("Switch pattern not taken as the base.");

  a_reset_defaults: assert property ( // [RL5] [RL10]
    cur_reg.st == ST_CAPTURE |-> cur_reg.base == SW_RESET &&
      cur_reg.board_lvl == BOARD_LVL_RESET &&
      cur_reg.link_lvl == LINK_LVL_RESET)
    else $error("Factory defaults not held before capture.");

  a_undriven_off: assert property ( // [RL11]
    1'b1 |=> ((~irq_oe_n_o & ~$past(irq_en_i)) == 16'h0000))
    else $error("Disabled level was driven.");

  a_legal_only: assert property ( // [RL9]
    (~irq_oe_n_o & ~LEGAL_IRQ_MASK) == 16'h0000)
    else $error("Illegal request level was driven.");

  a_link_level: assert property ( // [RL7]
    s_link_enabled |=> irq_o[$past(cur_reg.link_lvl)] &&
      !irq_oe_n_o[$past(cur_reg.link_lvl)])
    else $error("Link request not shown on its level.");

  a_link_on_board: assert property ( // [RL8] [RL6]
    (link_irq_i && irq_en_i[cur_reg.board_lvl] &&
      level_ok(cur_reg.board_lvl)) |=> irq_o[$past(cur_reg.board_lvl)])
    else $error("Link request did not raise the board level.");

  a_idle_low: assert property ( // [RL12]
    (!board_evt_i && !link_irq_i) |=> irq_o == 16'h0000)
    else $error("Request line high with no source.");

  // No strobe, or a DMA cycle, leaves every access strobe low.
  a_idle_no_hit: assert property ( // [RL3] [RL14]
    !io_req |=> !acc_o.hit && !acc_o.rd && !acc_o.wr)
    else $error("Access strobe without a bus strobe.");

  // Read and write strobes are passed on exactly as sampled.
  a_strobe_kind: assert property ( // [RL3]
    s_window_cycle |=> acc_o.rd == $past(!io_i.rd_n) &&
      acc_o.wr == $past(!io_i.wr_n))
    else $error("Access kind differs from the bus strobes.");

  // The register offset only moves when a window access is taken.
  a_offset_hold: assert property ( // [RL3]
    !(io_req && addr_match && cur_reg.st == ST_RUN) |=>
      $stable(acc_o.offset))
    else $error("Register offset changed without an access.");

  // Straps are taken once, so the base stays until the next reset.
  a_base_held: assert property ( // [RL2]
    cur_reg.st == ST_RUN |=> $stable(base_o))
    else $error("Base changed outside the capture phase.");

  // A status or error event shows on the board level when enabled.
  a_board_level: assert property ( // [RL6]
    (board_evt_i && irq_en_i[cur_reg.board_lvl] &&
      level_ok(cur_reg.board_lvl)) |=>
      irq_o[$past(cur_reg.board_lvl)] &&
      !irq_oe_n_o[$past(cur_reg.board_lvl)])
    else $error("Board event not shown on its level.");

  // Only the two selected levels may ever be driven.
  a_selected_only: assert property ( // [RL9] [RL12]
    1'b1 |=> (~irq_oe_n_o & ~((16'h0001 << $past(cur_reg.board_lvl)) |
      (16'h0001 << $past(cur_reg.link_lvl)))) == 16'h0000)
    else $error("Unselected request level was driven.");

  // A line that is left undriven never carries a request value.
  a_value_driven: assert property ( // [RL11]
    (irq_o & irq_oe_n_o) == 16'h0000)
    else $error("Request value on an undriven line.");

  // An enabled board level is driven even with no request pending.
  a_enabled_driven: assert property ( // [RL12]
    (irq_en_i[cur_reg.board_lvl] && level_ok(cur_reg.board_lvl)) |=>
      !irq_oe_n_o[$past(cur_reg.board_lvl)])
    else $error("Enabled board level was not driven.");

  // The link level drops one cycle after the link request ends, unless it is also the board level.
  a_link_release: assert property ( // [RL7]
    (!link_irq_i && cur_reg.link_lvl != cur_reg.board_lvl) |=>
      !irq_o[$past(cur_reg.link_lvl)])
    else $error("Link level high without a link request.");

endmodule

/* tb/isa_host_model.sv */
// Host side model that resolves the request lines seen by the host.
`timescale 1ns/1ps
module isa_host_model (
  input  wire logic        ref_clk_i,  // Bus clock.
  input  wire logic [15:0] irq_i,      // Values from the board.
  input  wire logic [15:0] irq_oe_n_i, // Low = board drives the line.
  output logic      [15:0] line_o      // Level the host sees.
);
  logic [15:0] float_reg = 16'h5555;
  // Undriven lines change every cycle so that a stale level never passes.
  always_ff @(posedge ref_clk_i) begin
    float_reg <= ~float_reg;
  end
  // Only the board drives a line it enables; the rest float.
  assign line_o = (irq_i & ~irq_oe_n_i) | (float_reg & irq_oe_n_i);
endmodule

/* tb/isa_io_decode_irq_route_bench.sv */
// Self-checking bench for the I/O decode and interrupt router.
`timescale 1ns/1ps
module isa_io_decode_irq_route_bench;
  import isa_dec_pkg::*;
  logic        ref_clk_i  = 1'b0;
  logic        rst_i      = 1'b1;
  io_cycle_t   io         = {10'h000, 1'b0, 1'b1, 1'b1};
  logic [4:0]  sw         = 5'h1a;
  logic [3:0]  bj         = 4'hc;
  logic [3:0]  lj         = 4'ha;
  logic        evt        = 1'b0;
  logic        lirq       = 1'b0;
  logic [15:0] en         = 16'h0000;
  reg_access_t acc;
  logic [4:0]  base;
  logic        bok;
  logic [15:0] irq;
  logic [15:0] oe_n;
  logic [15:0] line;
  int          fail_count = 0;
  int          n_compared = 0;
  logic [15:0] x;

  // Free-running 25 MHz clock.
  always #20 ref_clk_i = ~ref_clk_i;

  isa_io_decode_irq_route dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .io_i(io), .sw_off_i(sw), .board_jmp_i(bj), .link_jmp_i(lj),
    .board_evt_i(evt), .link_irq_i(lirq), .irq_en_i(en), .acc_o(acc),
    .base_o(base), .base_ok_o(bok), .irq_o(irq), .irq_oe_n_o(oe_n));
  isa_host_model host (.ref_clk_i(ref_clk_i), .irq_i(irq),
    .irq_oe_n_i(oe_n), .line_o(line));

  // Compares one value and reports a mismatch.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Resets with new straps and checks the reset state.
  task automatic do_reset(input logic [4:0] s, input logic [3:0] b);
    @(negedge ref_clk_i);
    rst_i = 1'b1;
    sw = s;
    bj = b;
    repeat (12) @(negedge ref_clk_i);
    check({11'h000, base}, 16'h001a);
    check(oe_n, 16'hffff);
    rst_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    check({11'h000, base}, {11'h000, s});
  endtask

  // One I/O cycle held for one edge; h says whether it must hit.
  task automatic bus(input logic [9:0] a, input logic r, input logic w,
                     input logic ae, input logic h);
    @(negedge ref_clk_i);
    io = {a, ae, ~r, ~w};
    @(negedge ref_clk_i);
    if (h) check({8'h00, acc}, {8'h00, 1'b1, r, w, a[4:0]});
    else check({15'h0000, acc.hit}, 16'h0000);
    io.rd_n = 1'b1;
    io.wr_n = 1'b1;
  endtask

  // Applies interrupt inputs, then checks drive and line levels.
  task automatic irq_step(input logic e, input logic l, input logic [15:0] n,
                          input logic [15:0] xi, input logic [15:0] xo);
    @(negedge ref_clk_i);
    evt = e;
    lirq = l;
    en = n;
    @(negedge ref_clk_i);
    check(oe_n, xo);
    check(line & ~xo, xi);
  endtask

  task automatic t_default;
    do_reset(5'h1a, 4'hc);
    check({15'h0000, bok}, 16'h0001);
    bus(10'h345, 1'b1, 1'b0, 1'b0, 1'b1);
    bus(10'h35f, 1'b0, 1'b1, 1'b0, 1'b1);
    bus(10'h34a, 1'b1, 1'b1, 1'b0, 1'b1);
    bus(10'h360, 1'b1, 1'b0, 1'b0, 1'b0);
    bus(10'h33f, 1'b0, 1'b1, 1'b0, 1'b0);
    bus(10'h345, 1'b1, 1'b0, 1'b1, 1'b0);
    $display("test default decode done");
  endtask

  task automatic t_irq;
    irq_step(1'b1, 1'b0, 16'h0000, 16'h0000, 16'hffff);
    irq_step(1'b1, 1'b0, 16'h1400, 16'h1000, 16'hebff);
    irq_step(1'b0, 1'b1, 16'h1400, 16'h1400, 16'hebff);
    irq_step(1'b0, 1'b0, 16'h1400, 16'h0000, 16'hebff);
    $display("test interrupt routing done");
  endtask

  task automatic t_levels;
    lj = 4'h0;
    for (int v = 0; v < 16; v++) begin
      do_reset(5'h08, v[3:0]);
      case (v)
        3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15: x = 16'h0001 << v;
        default: x = 16'h0000;
      endcase
      irq_step(1'b1, 1'b0, 16'hffff, x, ~x);
    end
    bus(10'h11f, 1'b1, 1'b0, 1'b0, 1'b1);
    $display("test level select done");
  endtask

  task automatic t_switches;
    do_reset(5'h10, 4'hc);
    bus(10'h205, 1'b1, 1'b0, 1'b0, 1'b1);
    bus(10'h105, 1'b1, 1'b0, 1'b0, 1'b0);
    do_reset(5'h07, 4'hc);
    check({15'h0000, bok}, 16'h0000);
    bus(10'h0e5, 1'b1, 1'b0, 1'b0, 1'b0);
    $display("test switch mapping done");
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    t_default();
    t_irq();
    t_levels();
    t_switches();
    end_sim();
  end
endmodule
